// ===== spi_pkg.sv
package spi_pkg;
  // ----------------------------------------------------------------
  // Register map: index as printed, byte address is four times it
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h32; // Control register
  localparam logic [7:0] IDX_STAT = 8'h33; // Status and control
  localparam logic [7:0] IDX_DATA = 8'h34; // Transmit / receive data
  localparam logic [7:0] IDX_PORT = 8'h35; // Shared port control
  localparam logic [7:0] ADR_CTRL = 8'(IDX_CTRL * 4);
  localparam logic [7:0] ADR_STAT = 8'(IDX_STAT * 4);
  localparam logic [7:0] ADR_DATA = 8'(IDX_DATA * 4);
  localparam logic [7:0] ADR_PORT = 8'(IDX_PORT * 4);
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CB_TIE  = 0; // transmit_irq_enable
  localparam int CB_SPE  = 1; // spi_enable
  localparam int CB_WOM  = 2; // wired_or_mode
  localparam int CB_CLOCK_PHASE = 3; // clock_phase
  localparam int CB_CLOCK_POLARITY = 4; // clock_polarity
  localparam int CB_MSTR = 5; // master_select
  localparam int CB_DMA  = 6; // dma_select, reads zero
  localparam int CB_RIE  = 7; // receive_irq_enable
  localparam logic [7:0] CTRL_RST   = 8'h28; // Master, phase 1
  localparam logic [7:0] CTRL_WMASK = 8'hBF; // dma_select not stored
  // ----------------------------------------------------------------
  // Status and control register fields
  // ----------------------------------------------------------------
  localparam int SB_BAUD_SELECT_LOW   = 0; // baud_select_low
  localparam int SB_BAUD_SELECT_HIGH   = 1; // baud_select_high
  localparam int SB_FAULT_DETECT_ENABLE = 2; // fault_detect_enable
  localparam int SB_TXE    = 3; // tx_empty
  localparam int SB_MODE_FAULT   = 4; // mode_fault
  localparam int SB_OVERFLOW_FLAG   = 5; // overflow_flag
  localparam int SB_ERRIE  = 6; // Error request enable
  localparam int SB_RXF    = 7; // rx_full
  localparam logic [7:0] STAT_WMASK = 8'h47; // Writable bits
  // ----------------------------------------------------------------
  // Baud divisors (half period in system clocks) and byte length
  // ----------------------------------------------------------------
  localparam logic [7:0] BD_00 = 8'd2;
  localparam logic [7:0] BD_01 = 8'd8;
  localparam logic [7:0] BD_10 = 8'd32;
  localparam logic [7:0] BD_11 = 8'd128;
  localparam logic [3:0] LAST_BIT = 4'd7; // Eight bits, 0 to 7
  // ----------------------------------------------------------------
  // Pin indices of the shared port, bus responses, states
  // ----------------------------------------------------------------
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK  = 2;
  localparam int PIN_SS   = 3;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic {M_IDLE, M_RUN} mstate_t;
endpackage

// ===== spi_pin_ctrl.sv
// Contract
// - see Wired-OR mode: pull-ups off, open drain
// - see MISO driven only by selected slave
// - see Deselected slave keeps MISO high impedance
// - see Enabled SPI owns serial pin directions
// - see Master drives clock; slave takes clock input
// - see One byte in eight clock cycles
// - see Phase 1: back-to-back bytes under select
// - see Slave always uses select as input
// - see Deselected slave ignores clock edges
// - see Master select use follows fault enable
// - see Disabled: select is general-purpose
// - see Select level readable through port register
// - see Receive request from rx_full when enabled
// - see dma_select reads zero, no effect
// - see master_select picks master or slave
// - see Idle clock level follows clock_polarity
// - see Phase and polarity time the data
// - see Clearing enable gives partial reset
// - see Transmit request from tx_empty when enabled
// - see Full, overflow, fault, empty flags
// - see Disabled: tx_empty set, transfer aborted
// - see Baud bits pick divisor 2/8/32/128
// - see Master with fault enable: low select faults
`timescale 1ns/1ps
module spi_pin_ctrl
  import spi_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE,
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE,
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  input  wire logic        SS_N_I,
  output logic             SS_N_O,
  output logic             SS_N_OE,
  output logic             PULLUP_EN,
  output logic             RX_REQ,
  output logic             TX_REQ,
  output logic             ERR_REQ
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;      // Control register
  logic [7:0]  stat_r;      // Writable status/control bits
  logic        txe_r;       // tx_empty
  logic        rxf_r;       // rx_full
  logic        overflow_flag_r;      // overflow_flag
  logic        mode_fault_r;      // mode_fault
  logic [2:0]  arm_r;       // Status read seen: rxf, overflow_flag, mode_fault
  logic [7:0]  txd_r;       // Transmit data register
  logic [7:0]  rxd_r;       // Receive data register
  logic [3:0]  pdir_r;      // Shared port direction
  logic [3:0]  pout_r;      // Shared port output data
  logic [3:0]  sync1_r;     // Pin synchroniser, first stage
  logic [3:0]  pin_s;       // Pin synchroniser, second stage
  logic        sck_d_r;     // Previous synced clock level
  logic        ss_d_r;      // Previous synced select level
  logic        aw_hold_r;   // Write address held
  logic        w_hold_r;    // Write data held
  logic [7:0]  aw_addr_r;   // Held write address
  logic [11:0] w_data_r;    // Held write data
  logic [1:0]  w_strb_r;    // Held byte enables
  logic [7:0]  rd_addr_r;   // Address of last read
  logic [7:0]  sh_r;        // Shift register
  logic [3:0]  cnt_r;       // Bits completed
  logic        phase_r;     // Between leading and trailing edge
  logic        samp_r;      // Sampled input bit
  logic        sbusy_r;     // Slave transfer under way
  logic [7:0]  div_r;       // Baud divider
  mstate_t     mst_r;       // Master sequencer
  logic        spi_enable, mstr, clock_polarity, clock_phase, wom, fault_detect_enable;
  logic        master_on, slave_on, slave_sel, ss_n_s;
  logic        wr_go, rd_go, wr_ctrl, wr_data, rd_stat, rd_data;
  logic        tick, lead, trail, byte_done, load, rx_in;
  logic        m_fault, s_fault, ss_gpio;
  logic [7:0]  bd, done_byte;
  logic [2:0]  s_val, s_drv;
  logic [3:0]  pin_o, pin_oe;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  assign spi_enable       = ctrl_r[CB_SPE];
  assign mstr      = ctrl_r[CB_MSTR];
  assign clock_polarity      = ctrl_r[CB_CLOCK_POLARITY];
  assign clock_phase      = ctrl_r[CB_CLOCK_PHASE];
  assign wom       = ctrl_r[CB_WOM];
  assign fault_detect_enable    = stat_r[SB_FAULT_DETECT_ENABLE];
  assign ss_n_s    = pin_s[PIN_SS];
  assign master_on = spi_enable && mstr;
  assign slave_on  = spi_enable && !mstr;
  assign slave_sel = slave_on && !ss_n_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops on every pin before any logic reads it
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sync1_r <= 4'h0;
      pin_s   <= 4'h0;
    end
    else
    begin
      sync1_r <= {SS_N_I, SCK_I, MOSI_I, MISO_I};
      pin_s   <= sync1_r;
    end
  end

  // Edge history of clock and select
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sck_d_r <= 1'b0;
      ss_d_r  <= 1'b1;
    end
    else
    begin
      sck_d_r <= pin_s[PIN_SCK];
      ss_d_r  <= ss_n_s;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign AWREADY = !aw_hold_r && !BVALID;
  assign WREADY  = !w_hold_r && !BVALID;
  assign ARREADY = !RVALID;
  assign wr_go   = aw_hold_r && w_hold_r;
  assign rd_go   = ARVALID && ARREADY;
  assign wr_ctrl = wr_go && aw_addr_r == ADR_CTRL && w_strb_r[0];
  assign wr_data = wr_go && aw_addr_r == ADR_DATA && w_strb_r[0];
  assign rd_stat = rd_go && ARADDR == ADR_STAT;
  assign rd_data = rd_go && ARADDR == ADR_DATA;

  // Write channel: address and data in either order
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 12'h000;
      w_strb_r  <= 2'b00;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= WDATA[11:0];
        w_strb_r <= WSTRB[1:0];
      end
      if (wr_go)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        BVALID    <= 1'b1;
        // Unmapped address answers with a slave error
        BRESP <= (aw_addr_r inside {ADR_CTRL, ADR_STAT, ADR_DATA,
                  ADR_PORT}) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  // Read data multiplexer
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ARADDR)
      ADR_CTRL: rd_word[7:0] = ctrl_r;
      ADR_STAT: rd_word[7:0] = {rxf_r, stat_r[SB_ERRIE], overflow_flag_r,
                                mode_fault_r, txe_r, stat_r[2:0]};
      ADR_DATA: rd_word[7:0] = rxd_r;
      // Pin levels always visible, select among them
      ADR_PORT: rd_word = {12'h000, pin_s, 4'h0, pout_r, 4'h0,
                           pdir_r};
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RVALID    <= 1'b0;
      RDATA     <= 32'h0000_0000;
      RRESP     <= RESP_OKAY;
      rd_addr_r <= 8'h00;
    end
    else if (rd_go)
    begin
      RVALID    <= 1'b1;
      RDATA     <= rd_word;
      rd_addr_r <= ARADDR;
      RRESP     <= (ARADDR inside {ADR_CTRL, ADR_STAT, ADR_DATA,
                    ADR_PORT}) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID && RREADY)
      RVALID <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Control register; a master mode fault drops the enable
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ctrl_r <= CTRL_RST;
    else if (m_fault)
      ctrl_r[CB_SPE] <= 1'b0;
    else if (wr_ctrl)
      ctrl_r <= w_data_r[7:0] & CTRL_WMASK;
  end

  // Status writable bits and shared port control
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      stat_r <= 8'h00;
      pdir_r <= 4'h0;
      pout_r <= 4'h0;
    end
    else if (wr_go)
    begin
      if (aw_addr_r == ADR_STAT && w_strb_r[0])
        stat_r <= w_data_r[7:0] & STAT_WMASK;
      if (aw_addr_r == ADR_PORT && w_strb_r[0])
        pdir_r <= w_data_r[3:0];
      if (aw_addr_r == ADR_PORT && w_strb_r[1])
        pout_r <= w_data_r[11:8];
    end
  end

  // ----------------------------------------------------------------
  // Baud divider and master sequencer
  // ----------------------------------------------------------------
  // Half period in system clocks from the two baud bits
  always_comb
  begin
    case (stat_r[SB_BAUD_SELECT_HIGH:SB_BAUD_SELECT_LOW])
      2'b00:   bd = BD_00;
      2'b01:   bd = BD_01;
      2'b10:   bd = BD_10;
      default: bd = BD_11;
    endcase
  end

  assign tick = master_on && mst_r == M_RUN && div_r == bd - 8'd1;
  assign load = !phase_r && cnt_r == 4'd0 && !txe_r &&
                ((master_on && mst_r == M_IDLE) ||
                 (slave_on && !sbusy_r));

  // Master runs from load until the eighth trailing edge
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !master_on)
    begin
      mst_r <= M_IDLE;
      div_r <= 8'h00;
    end
    else
    begin
      case (mst_r)
        M_IDLE:
        begin
          div_r <= 8'h00;
          if (load)
            mst_r <= M_RUN;
        end
        M_RUN:
        begin
          div_r <= tick ? 8'h00 : div_r + 8'd1;
          if (byte_done)
            mst_r <= M_IDLE;
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Edge events and shift engine
  // ----------------------------------------------------------------
  // Leading edge leaves the idle level, trailing edge returns to it
  assign lead  = (tick && !phase_r) || (slave_sel &&
                 pin_s[PIN_SCK] != sck_d_r && pin_s[PIN_SCK] != clock_polarity);
  assign trail = (tick && phase_r) || (slave_sel &&
                 pin_s[PIN_SCK] != sck_d_r && pin_s[PIN_SCK] == clock_polarity);
  assign rx_in = mstr ? pin_s[PIN_MISO] : pin_s[PIN_MOSI];
  assign byte_done = trail && cnt_r == LAST_BIT;
  assign done_byte = {sh_r[6:0], clock_phase ? rx_in : samp_r};

  // Phase 0 samples on lead, phase 1 shifts on lead
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !spi_enable)
    begin
      sh_r    <= 8'h00;
      cnt_r   <= 4'd0;
      phase_r <= 1'b0;
      samp_r  <= 1'b0;
    end
    else if (slave_on && ss_n_s)
    begin
      cnt_r   <= 4'd0;
      phase_r <= 1'b0;
    end
    else if (load)
      sh_r <= txd_r;
    else if (lead)
    begin
      phase_r <= 1'b1;
      if (!clock_phase)
        samp_r <= rx_in;
      else if (cnt_r != 4'd0)
        sh_r <= {sh_r[6:0], samp_r};
    end
    else if (trail)
    begin
      phase_r <= 1'b0;
      cnt_r   <= byte_done ? 4'd0 : cnt_r + 4'd1;
      if (clock_phase)
        samp_r <= rx_in;
      else
        sh_r <= {sh_r[6:0], samp_r};
    end
  end

  // Slave transfer span: phase 0 from select fall, phase 1 from lead
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !slave_on || ss_n_s)
      sbusy_r <= 1'b0;
    else if (byte_done)
      sbusy_r <= 1'b0;
    else if (clock_phase ? lead : ss_d_r)
      sbusy_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign m_fault = master_on && fault_detect_enable && !ss_n_s;
  assign s_fault = slave_on && fault_detect_enable && ss_n_s && sbusy_r;

  // Flags: a set in the same cycle as its clear wins
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      txe_r  <= 1'b1;
      rxf_r  <= 1'b0;
      overflow_flag_r <= 1'b0;
      mode_fault_r <= 1'b0;
      arm_r  <= 3'b000;
      txd_r  <= 8'h00;
      rxd_r  <= 8'h00;
    end
    else
    begin
      if (rd_stat)
        arm_r <= {rxf_r, overflow_flag_r, mode_fault_r};
      if (wr_data)
        txd_r <= w_data_r[7:0];
      if (!spi_enable || load)
        txe_r <= 1'b1;
      else if (wr_data)
        txe_r <= 1'b0;
      if (byte_done && !rxf_r)
      begin
        rxf_r <= 1'b1;
        rxd_r <= done_byte;
      end
      else if (rd_data && arm_r[2])
        rxf_r <= 1'b0;
      if (byte_done && rxf_r)
        overflow_flag_r <= 1'b1;
      else if (rd_data && arm_r[1])
        overflow_flag_r <= 1'b0;
      if (m_fault || s_fault)
        mode_fault_r <= 1'b1;
      else if (wr_ctrl && arm_r[0])
        mode_fault_r <= 1'b0;
    end
  end

  // Request outputs
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RX_REQ  <= 1'b0;
      TX_REQ  <= 1'b0;
      ERR_REQ <= 1'b0;
    end
    else
    begin
      RX_REQ  <= ctrl_r[CB_RIE] && rxf_r;
      TX_REQ  <= ctrl_r[CB_TIE] && txe_r && spi_enable;
      ERR_REQ <= stat_r[SB_ERRIE] && (overflow_flag_r || mode_fault_r);
    end
  end

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  assign ss_gpio = !spi_enable || (mstr && !fault_detect_enable);
  assign s_val = {clock_polarity ^ phase_r, sh_r[7], sh_r[7]};
  assign s_drv = {master_on, master_on, slave_sel};

  // Port owns pins while disabled; enabled SPI owns serial pins
  always_comb
  begin
    pin_o  = pout_r;
    pin_oe = pdir_r;
    if (spi_enable)
    begin
      for (int i = 0; i < 3; i++)
      begin
        pin_o[i]  = wom ? 1'b0 : s_val[i];
        pin_oe[i] = wom ? (s_drv[i] && !s_val[i]) : s_drv[i];
      end
    end
    if (!ss_gpio)
      pin_oe[PIN_SS] = 1'b0;
  end

  assign MISO_O    = pin_o[PIN_MISO];
  assign MISO_OE   = pin_oe[PIN_MISO];
  assign MOSI_O    = pin_o[PIN_MOSI];
  assign MOSI_OE   = pin_oe[PIN_MOSI];
  assign SCK_O     = pin_o[PIN_SCK];
  assign SCK_OE    = pin_oe[PIN_SCK];
  assign SS_N_O    = pin_o[PIN_SS];
  assign SS_N_OE   = pin_oe[PIN_SS];
  assign PULLUP_EN = !wom;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_master_go;
    (mst_r == M_IDLE) ##1 (mst_r == M_RUN);
  endsequence

  AST_MISO_SLAVE_ONLY:
    assert property ((spi_enable && MISO_OE) |-> (!mstr && !ss_n_s))
    else $error("MISO driven while not a selected slave");
  AST_MISO_HIZ:
    assert property ((spi_enable && !mstr && ss_n_s) |-> !MISO_OE)
    else $error("MISO driven while deselected");
  AST_WIRED_OR:
    assert property ((spi_enable && wom && SCK_OE) |-> (!SCK_O && !PULLUP_EN))
    else $error("Wired-OR clock driven high");
  AST_MASTER_CLK:
    assert property ((master_on && !wom) |-> SCK_OE)
    else $error("Master not driving serial clock");
  AST_IDLE_LEVEL:
    assert property ((master_on && mst_r == M_IDLE && !wom) |->
                     SCK_O == clock_polarity)
    else $error("Serial clock off idle level");
  AST_PARTIAL_RESET:
    assert property ((!spi_enable && !wr_ctrl) |=>
                     (txe_r && cnt_r == 4'd0 && !SCK_OE))
    else $error("Partial reset incomplete");
  AST_DMA_ZERO:
    assert property ((RVALID && rd_addr_r == ADR_CTRL) |-> !RDATA[CB_DMA])
    else $error("dma_select read as one");
  AST_RX_REQ:
    assert property ((byte_done && !rxf_r && ctrl_r[CB_RIE]) |=>
                     ##1 RX_REQ)
    else $error("Receive request missing");
  AST_MASTER_FAULT:
    assert property ((master_on && fault_detect_enable && !ss_n_s) |=>
                     (mode_fault_r && !spi_enable))
    else $error("Master mode fault not taken");
  AST_DESELECT:
    assert property ((slave_on && ss_n_s) |=> cnt_r == 4'd0)
    else $error("Deselected slave counted a bit");
  AST_EIGHT_BITS:
    assert property ($rose(rxf_r) |-> $past(cnt_r) == LAST_BIT)
    else $error("Byte completed at wrong bit count");
  AST_TX_EMPTY_LOAD:
    assert property (s_master_go |-> txe_r)
    else $error("tx_empty not set at load");
endmodule

// ===== spi_far_slave.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side slave: polarity 0, phase 1
// ------------------------------------------------------------
module spi_far_slave
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       clr,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx,
  output int              edges
);
  int k;  // Bits finished in this frame
  initial miso = 1'b0;
  // Frame start: counts cleared
  always @(posedge clr)
  begin
    k = 0;
    edges = 0;
  end
  // Leading edge presents the next bit
  always @(posedge sck)
  begin
    miso = tx[7 - k];
    edges++;
  end
  // Trailing edge takes MOSI; line flips once the frame ends
  always @(negedge sck)
  begin
    rx = {rx[6:0], mosi};
    edges++;
    k++;
    if (k == 8)
      miso = ~miso;
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import spi_pkg::*;
  // ------------------------------------------------------------
  // Bus, pins and scoreboard
  // ------------------------------------------------------------
  logic        clk = 1'b0, rst_n = 1'b0, clr = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, far_tx = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1, ss_n = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, pullup_en;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        miso_o, miso_oe, mosi_o, mosi_oe, sck_o, sck_oe;
  logic        ss_n_o, ss_n_oe, rx_req, tx_req, err_req, far_miso;
  logic [7:0]  far_rx, got, txb;
  logic [17:0] exp_q[$];  // Expected {resp, mask, data}
  logic [17:0] e;
  int          num_errors = 0, total_checks = 0, edges;
  wire         miso_w = miso_oe ? miso_o : far_miso;
  wire         mosi_w = mosi_oe ? mosi_o : pullup_en;  // Pull-up level
  wire         sck_w  = sck_oe ? sck_o : pullup_en;
  initial forever #20 clk = ~clk;
  spi_pin_ctrl DUT (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE(sck_oe), .SS_N_I(ss_n), .SS_N_O(ss_n_o),
    .SS_N_OE(ss_n_oe), .PULLUP_EN(pullup_en), .RX_REQ(rx_req),
    .TX_REQ(tx_req), .ERR_REQ(err_req));
  spi_far_slave far (.sck(sck_w), .mosi(mosi_w), .clr(clr),
    .tx(far_tx), .miso(far_miso), .rx(far_rx), .edges(edges));
  // ------------------------------------------------------------
  // Verdict, compare and bus tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic stop();  // Wait ran out
    num_errors++;
    test_done();
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("BAD %0t pin got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      aw = awvalid & awready;
      w  = wvalid & wready;
      b  = bvalid;
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (b)
        break;
    end
    if (!b)
      stop();
  endtask
  task automatic rd(input logic [7:0] a, x, m, input logic [1:0] r,
                    output logic [7:0] q);
    logic ar, v;
    v = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    exp_q.push_back({r, m, x & m});
    repeat (50)
    begin
      @(negedge clk);
      ar = arvalid & arready;
      v  = rvalid;
      q  = rdata[7:0];
      @(posedge clk);
      if (ar)
        arvalid <= 1'b0;
      if (v)
        break;
    end
    if (!v)
      stop();
  endtask
  // Watcher: each read answer is matched to the oldest note
  always @(negedge clk)
    if (rvalid === 1'b1)
    begin
      e = exp_q.pop_front();
      total_checks++;
      if ((rdata[7:0] & e[15:8]) !== e[7:0] || rresp !== e[17:16])
      begin
        num_errors++;
        $display("BAD %0t read %h resp %b", $time, rdata[7:0], rresp);
      end
    end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hcf57_130e));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADR_CTRL, 8'h28, 8'hFF, RESP_OKAY, got);
    rd(ADR_STAT, 8'h08, 8'hFF, RESP_OKAY, got);
    chk(8'({pullup_en, sck_oe, mosi_oe, miso_oe, tx_req}), 8'h10);
    rd(8'h10, 8'h00, 8'hFF, RESP_SLVERR, got);
    wr(ADR_CTRL, 8'h7B);
    rd(ADR_CTRL, 8'h3B, 8'hFF, RESP_OKAY, got);
    @(negedge clk);
    chk(8'({ss_n_oe, sck_oe, mosi_oe, miso_oe, sck_o, tx_req}), 8'h1B);
    @(posedge clk);
    txb = 8'($urandom);
    wr(ADR_STAT, 8'($urandom_range(3)));
    wr(ADR_CTRL, 8'hAA);
    far_tx <= 8'($urandom);
    clr    <= 1'b1;
    wr(ADR_DATA, txb);
    got = 8'h00;
    for (int i = 0; i < 1000 && got[7] !== 1'b1; i++)
      rd(ADR_STAT, 8'h00, 8'h00, RESP_OKAY, got);
    if (got[7] !== 1'b1)
      stop();
    @(negedge clk);
    chk(8'({rx_req, tx_req}), 8'h02);
    @(posedge clk);
    rd(ADR_DATA, far_tx, 8'hFF, RESP_OKAY, got);
    repeat (2) @(negedge clk);
    chk(far_rx, txb);
    chk(8'(edges), 8'd16);
    chk(8'({sck_o, rx_req}), 8'h00);
    @(posedge clk);
    wr(ADR_CTRL, 8'h28);
    rd(ADR_STAT, 8'h08, 8'h08, RESP_OKAY, got);
    rd(ADR_CTRL, 8'h28, 8'hFF, RESP_OKAY, got);
    @(negedge clk);
    chk(8'({sck_oe, mosi_oe, miso_oe, ss_n_oe}), 8'h00);
    @(posedge clk);
    wr(ADR_CTRL, 8'h2E);
    @(negedge clk);
    chk(8'(pullup_en), 8'h00);
    @(posedge clk);
    ss_n <= 1'b0;
    wr(ADR_STAT, 8'h44);
    repeat (6) @(negedge clk);
    chk(8'({err_req, mosi_oe}), 8'h02);
    @(posedge clk);
    rd(ADR_CTRL, 8'h2C, 8'hFF, RESP_OKAY, got);
    test_done();
  end
endmodule
